// file: fmt_pkg.sv
// Package: register map, field layout, reset values and codes of the output format bank
package fmt_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 10;
    // Byte addresses are the word index times four
    localparam logic [7:0] IDX_DATA_OUTPUT_CONFIG = 8'h14;
    localparam logic [7:0] IDX_OUTPUT_DRIVE_TRIM = 8'h15;
    localparam logic [7:0] IDX_CLOCK_PHASE_SELECT = 8'h16;
    localparam logic [7:0] IDX_PATTERN_ONE_LOW = 8'h19;
    localparam logic [7:0] IDX_PATTERN_ONE_HIGH = 8'h1a;
    localparam logic [7:0] IDX_TEST_MODE = 8'h0d;
    // Write masks: only documented fields hold state
    localparam logic [7:0] MASK_DATA_OUTPUT_CONFIG = 8'h47;
    localparam logic [7:0] MASK_OUTPUT_DRIVE_TRIM = 8'h30;
    localparam logic [7:0] MASK_CLOCK_PHASE_SELECT = 8'h0f;
    localparam logic [7:0] MASK_PATTERN = 8'hff;
    localparam logic [7:0] MASK_TEST_MODE = 8'h0f;
    localparam logic [7:0] RST_DATA_OUTPUT_CONFIG = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DRIVE_TRIM = 8'h00;
    localparam logic [7:0] RST_CLOCK_PHASE_SELECT = 8'h03;
    localparam logic [7:0] RST_PATTERN = 8'h00;
    localparam logic [7:0] RST_TEST_MODE = 8'h00;
    // Field positions
    localparam int POS_CODING = 0;
    localparam int POS_INVERT = 2;
    localparam int POS_LOW_POWER = 6;
    localparam int POS_TERM = 4;
    localparam logic [1:0] CODING_OFFSET = 2'h0;
    localparam logic [1:0] CODING_TWOS = 2'h1;
    localparam logic [3:0] TEST_USER = 4'h8;
    localparam logic [3:0] PHASE_MAX = 4'ha;
    localparam int PHASE_STEP_DEG = 60;

    typedef struct packed {
        logic [1:0] coding;
        logic invert;
        logic low_power;
        logic [1:0] term;
        logic [3:0] phase;
        logic [3:0] test_mode;
        logic [15:0] pattern;
    } fmt_cfg_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [DATA_W-1:0] dat;
    } wb_req_type;
endpackage

// file: fmt_byte_reg.sv
// Module: one masked byte register with reset value and write-enable
module fmt_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hff
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    logic [7:0] value_q;
    logic [7:0] value_d;

    assign value_d = wr_en ? (wr_data & WRITE_MASK) : value_q;
    assign value = value_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end else begin
            value_q <= value_d;
        end
    end
endmodule // fmt_byte_reg

// file: adc_output_format_regs.sv
// Module: output format register bank on classic Wishbone, with formatted sample path
// Notes on behaviour
// - A four-bit phase code sets the capture clock offset from data edges, 60 degrees a step.
// - The phase code resets to three and reads back 0x03; the degree output resets to 0 and reads 180 from the first clock after reset.
// - Pattern bits seven to zero sit in their own byte register resetting to zero.
// - Pattern bits fifteen to eight sit in a second byte register resetting to zero.
// - With the user test mode selected, the stored pattern replaces sample data.
// - Test patterns follow the selected data coding and inversion.
//
// Decided for this implementation: the Wishbone register port.
module adc_output_format_regs
    import fmt_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic sample_valid,
    input wire logic [WIDTH-1:0] sample_data,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    output logic [3:0] bit_capture_clock_phase,
    output logic [9:0] bit_capture_clock_deg,
    output logic low_power_drive,
    output logic [1:0] drive_term
);
    if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
        $error("WIDTH must lie in 2..16");
    end

    wb_req_type req;
    assign req = '{
        cyc: wb_cyc_i,
        stb: wb_stb_i,
        we: wb_we_i,
        adr: wb_adr_i,
        sel: wb_sel_i,
        dat: wb_dat_i
    };

    // Bus decode: word aligned, index is address bits above the byte lanes
    wire logic [5:0] idx = req.adr[7:2];
    wire logic aligned = (req.adr[1:0] == 2'h0);
    wire logic access = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    wire logic hit_cfg = aligned && ({2'h0, idx} == IDX_DATA_OUTPUT_CONFIG);
    wire logic hit_trim = aligned && ({2'h0, idx} == IDX_OUTPUT_DRIVE_TRIM);
    wire logic hit_phase = aligned && ({2'h0, idx} == IDX_CLOCK_PHASE_SELECT);
    wire logic hit_low = aligned && ({2'h0, idx} == IDX_PATTERN_ONE_LOW);
    wire logic hit_high = aligned && ({2'h0, idx} == IDX_PATTERN_ONE_HIGH);
    wire logic hit_test = aligned && ({2'h0, idx} == IDX_TEST_MODE);
    wire logic mapped = hit_cfg | hit_trim | hit_phase | hit_low | hit_high | hit_test;
    // Writes land through byte lane zero only
    wire logic wr_lane0 = access && req.we && req.sel[0];
    // Phase codes above ten are refused; the register keeps its value
    wire logic phase_ok = (req.dat[3:0] <= PHASE_MAX);

    // Register slices
    logic [7:0] cfg_v;
    logic [7:0] trim_v;
    logic [7:0] phase_v;
    logic [7:0] low_v;
    logic [7:0] high_v;
    logic [7:0] test_v;

    fmt_byte_reg #(.RESET_VALUE(RST_DATA_OUTPUT_CONFIG), .WRITE_MASK(MASK_DATA_OUTPUT_CONFIG))
        u_cfg (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_cfg),
               .wr_data(req.dat[7:0]), .value(cfg_v));
    fmt_byte_reg #(.RESET_VALUE(RST_OUTPUT_DRIVE_TRIM), .WRITE_MASK(MASK_OUTPUT_DRIVE_TRIM))
        u_trim (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_trim),
                .wr_data(req.dat[7:0]), .value(trim_v));
    fmt_byte_reg #(.RESET_VALUE(RST_CLOCK_PHASE_SELECT), .WRITE_MASK(MASK_CLOCK_PHASE_SELECT))
        u_phase (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_phase && phase_ok),
                 .wr_data(req.dat[7:0]), .value(phase_v));
    fmt_byte_reg #(.RESET_VALUE(RST_PATTERN), .WRITE_MASK(MASK_PATTERN))
        u_low (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_low),
               .wr_data(req.dat[7:0]), .value(low_v));
    fmt_byte_reg #(.RESET_VALUE(RST_PATTERN), .WRITE_MASK(MASK_PATTERN))
        u_high (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_high),
                .wr_data(req.dat[7:0]), .value(high_v));
    fmt_byte_reg #(.RESET_VALUE(RST_TEST_MODE), .WRITE_MASK(MASK_TEST_MODE))
        u_test (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_lane0 && hit_test),
                .wr_data(req.dat[7:0]), .value(test_v));

    fmt_cfg_type cfg;
    assign cfg = '{
        coding: cfg_v[POS_CODING +: 2],
        invert: cfg_v[POS_INVERT],
        low_power: cfg_v[POS_LOW_POWER],
        term: trim_v[POS_TERM +: 2],
        phase: phase_v[3:0],
        test_mode: test_v[3:0],
        pattern: {high_v, low_v}
    };

    // Read mux
    wire logic [7:0] rd_byte = hit_cfg ? cfg_v :
                               hit_trim ? trim_v :
                               hit_phase ? phase_v :
                               hit_low ? low_v :
                               hit_high ? high_v :
                               hit_test ? test_v : 8'h00;

    // Sample path: user pattern replaces data, then coding and inversion apply
    wire logic user_sel = (cfg.test_mode == TEST_USER);
    wire logic [WIDTH-1:0] raw = user_sel ? cfg.pattern[15 -: WIDTH] : sample_data;
    wire logic [WIDTH-1:0] msb_flip = {1'b1, {(WIDTH-1){1'b0}}};
    wire logic [WIDTH-1:0] coded = (cfg.coding == CODING_TWOS) ? (raw ^ msb_flip) : raw;
    wire logic [WIDTH-1:0] formatted = cfg.invert ? ~coded : coded;
    wire logic [9:0] deg = 10'(int'(cfg.phase) * PHASE_STEP_DEG);

    // Next values of the output registers
    wire logic ack_d = access && mapped;
    wire logic err_d = access && !mapped;
    wire logic [DATA_W-1:0] dat_d = (access && mapped && !req.we) ? {24'h0, rd_byte} : '0;
    wire logic valid_d = sample_valid || user_sel;
    wire logic [WIDTH-1:0] data_d = formatted;
    wire logic [3:0] ph_d = cfg.phase;
    wire logic [9:0] deg_d = deg;
    wire logic lp_d = cfg.low_power;
    wire logic [1:0] term_d = cfg.term;

    logic [DATA_W-1:0] dat_q;
    logic ack_q;
    logic err_q;
    logic valid_q;
    logic [WIDTH-1:0] data_q;
    logic [3:0] ph_q;
    logic [9:0] deg_q;
    logic lp_q;
    logic [1:0] term_q;

    // Bus answer: one-cycle ack or err, read data only beside ack
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dat_q <= '0;
        end else begin
            dat_q <= dat_d;
        end
    end

    // Sample path registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            data_q <= '0;
        end else begin
            data_q <= data_d;
        end
    end

    // Pin registers
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ph_q <= RST_CLOCK_PHASE_SELECT[3:0];
        end else begin
            ph_q <= ph_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            deg_q <= '0;
        end else begin
            deg_q <= deg_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            lp_q <= 1'b0;
        end else begin
            lp_q <= lp_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            term_q <= 2'h0;
        end else begin
            term_q <= term_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = dat_q;
    assign out_valid = valid_q;
    assign out_data = data_q;
    assign bit_capture_clock_phase = ph_q;
    assign bit_capture_clock_deg = deg_q;
    assign low_power_drive = lp_q;
    assign drive_term = term_q;
endmodule // adc_output_format_regs

// file: fmt_checker.sv
// Checker for the output format register bank ports
module fmt_checker import fmt_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic sample_valid,
    input wire logic out_valid,
    input wire logic [3:0] bit_capture_clock_phase,
    input wire logic [9:0] bit_capture_clock_deg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    a_bus_answer: assert property (req |=> wb_ack_o ^ wb_err_o)
        else $error("no single answer to request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_phase_reset: assert property ($rose(reset_n) |-> bit_capture_clock_phase == 4'h3)
        else $error("phase code not three after reset");
    a_phase_range: assert property (bit_capture_clock_phase <= PHASE_MAX)
        else $error("phase code above ten");
    a_deg_step: assert property ($past(reset_n, 2) |->
        bit_capture_clock_deg == {6'h0, bit_capture_clock_phase} * 10'd60)
        else $error("phase degrees not code times sixty");
    a_valid_follow: assert property ($past(sample_valid) && $past(reset_n) |-> out_valid)
        else $error("sample strobe lost");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_read_phase: assert property ($past(req && !wb_we_i && wb_adr_i == 8'h58) && wb_ack_o
        |-> wb_dat_o == {28'h0, bit_capture_clock_phase})
        else $error("phase readback differs from output");
    c_read: cover property (wb_ack_o && !wb_we_i);
    c_err: cover property (wb_err_o);
    c_out: cover property (out_valid);
endmodule // fmt_checker
bind adc_output_format_regs fmt_checker fmt_checker_inst(.mclk, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .sample_valid, .out_valid,
    .bit_capture_clock_phase, .bit_capture_clock_deg);

// file: capture_model.sv
// Model of the capture logic that takes formatted samples on out_valid and inverts its held data on other cycles
module capture_model import fmt_pkg::*; (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic out_valid,
    input wire logic [SAMPLE_W-1:0] out_data,
    output logic cap_valid,
    output logic [SAMPLE_W-1:0] cap_data
);
    always_ff @(posedge mclk) begin
        cap_valid <= reset_n && out_valid;
        cap_data <= out_valid ? out_data : ~cap_data;
    end
endmodule // capture_model

// file: test_adc_output_format_regs.sv
// Testbench for the output format register bank
module test_adc_output_format_regs import fmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, sv = 0, ack, err, ov, lp, cv;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0, ph;
    logic [3:0] lane = 4'h1;
    logic [31:0] wd = 0, rdat, bq[$];
    logic [9:0] sd = 0, od, cd, sq[$];
    logic [9:0] deg;
    logic [1:0] term;
    logic [7:0] ra[6] = '{8'h50, 8'h54, 8'h58, 8'h64, 8'h68, 8'h34};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    int num_errors = 0, check_count = 0;
    always #50 mclk = ~mclk;
    adc_output_format_regs adc_output_format_regs_inst(.mclk(mclk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .sample_valid(sv),
        .sample_data(sd), .out_valid(ov), .out_data(od), .bit_capture_clock_phase(ph),
        .bit_capture_clock_deg(deg), .low_power_drive(lp), .drive_term(term));
    capture_model capture_model_inst(.mclk(mclk), .reset_n(reset_n), .out_valid(ov),
        .out_data(od), .cap_valid(cv), .cap_data(cd));
    task report_and_stop;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wd <= {24'h0, d};
        sel <= lane;
        do begin
            @(posedge mclk);
            n++;
        end while (!(ack || err) && n < 20);
        if (n >= 20) begin
            num_errors++;
            report_and_stop;
        end
        cyc <= 0;
        stb <= 0;
        @(posedge mclk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        bq.push_back({24'h0, e});
        bus(0, a, 8'h00);
    endtask
    task send(input logic [9:0] x, input logic [9:0] e);
        sq.push_back(e);
        sv <= 1;
        sd <= x;
        @(posedge mclk);
        sv <= 0;
        repeat (4) @(posedge mclk);
    endtask
    function automatic logic [9:0] fmt(input logic [9:0] r, input logic [1:0] m);
        if (m[0]) r[9] = ~r[9];
        if (m[1]) r = ~r;
        return r;
    endfunction
    always @(posedge mclk) begin
        if ((ack || err) && !we && bq.size() > 0) chk(rdat, bq.pop_front());
        if (cv && sq.size() > 0) chk({22'h0, cd}, sq.pop_front());
    end
    initial begin
        logic [7:0] e;
        logic [15:0] p;
        void'($urandom(32'h0caeb662));
        repeat (4) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        chk({28'h0, ph}, 32'h3);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h40, 8'h00);
        $display("test reset_map done");
        e = 8'h03;
        for (int c = 0; c < 16; c++) begin
            bus(1, 8'h58, c[7:0]);
            if (c <= 10) e = c[7:0];
            rd(8'h58, e);
            chk({28'h0, ph}, {24'h0, e});
            chk({22'h0, deg}, {24'h0, e} * 32'd60);
        end
        $display("test phase done");
        p = 16'($urandom);
        bus(1, 8'h64, p[7:0]);
        bus(1, 8'h68, p[15:8]);
        rd(8'h64, p[7:0]);
        rd(8'h68, p[15:8]);
        lane = 4'h0;
        bus(1, 8'h64, ~p[7:0]);
        lane = 4'h1;
        rd(8'h64, p[7:0]);
        rd(8'h65, 8'h00);
        e = 8'($urandom);
        bus(1, 8'h54, e);
        bus(1, 8'h50, e);
        rd(8'h54, e & MASK_OUTPUT_DRIVE_TRIM);
        rd(8'h50, e & MASK_DATA_OUTPUT_CONFIG);
        chk({30'h0, term}, {30'h0, e[5:4]});
        chk({31'h0, lp}, {31'h0, e[6]});
        $display("test pattern done");
        for (int m = 0; m < 4; m++) begin
            bus(1, 8'h50, {5'h0, m[1], 1'b0, m[0]});
            e = 8'($urandom);
            send({e, 2'h1}, fmt({e, 2'h1}, m[1:0]));
            bus(1, 8'h34, 8'h08);
            repeat (3) @(posedge mclk);
            send({e, 2'h2}, fmt(p[15:6], m[1:0]));
            bus(1, 8'h34, 8'h00);
            repeat (4) @(posedge mclk);
        end
        $display("test format done");
        report_and_stop;
    end
endmodule // test_adc_output_format_regs
